// [sau_clock_gate.sv]
/*
  Clock gate and two-output power-of-two prescaler for serial unit 0,
  with an APB register slave.
  Assumes one system clock at 200 MHz and a synchronous active-high reset.
*/
// The register offsets and the APB register port were left to the implementer.
module serial_unit_clock_gate_prescaler
  import serial_clock_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
)
(
  input  wire  logic                clk,
  input  wire  logic                srst,
  input  wire  logic                psel,
  input  wire  logic                penable,
  input  wire  logic                pwrite,
  input  wire  logic [ADDR_W-1:0]   paddr,
  input  wire  logic [31:0]         pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  output logic                      unit_clock,
  output logic                      unit_clock_on,
  output logic                      prescaled_clock_a,
  output logic                      prescaled_clock_b,
  output logic [CHANNELS-1:0]       channel_operation_clock
);

  logic [ENABLE_W-1:0] peripheral_clock_enable_reg;
  logic [SPS_W-1:0]    serial_prescaler_reg;
  logic [CHANNELS-1:0] channel_clock_source_reg;
  logic [DIV_W-1:0]    div_count_reg;
  logic                unit_phase_reg;
  logic                gate_open_reg;
  logic                tick_a_reg;
  logic                tick_b_reg;
  logic [CHANNELS-1:0] chan_tick_reg;
  logic [31:0]         prdata_reg;
  logic                pready_reg;
  logic                pslverr_reg;

  // Pulse when the free counter completes a 2**code period
  function automatic logic divide_tick(input logic [CODE_W-1:0] code,
                                       input logic [DIV_W-1:0] count);
    logic [DIV_W-1:0] mask;
    mask = DIV_W'((DIV_W'(1) << code) - DIV_W'(1));
    divide_tick = ((count & mask) == mask);
  endfunction

  // Prohibited codes are refused and the old field kept
  function automatic logic [CODE_W-1:0] legal_code(
    input logic [CODE_W-1:0] new_code,
    input logic [CODE_W-1:0] old_code);
    legal_code = (new_code > CODE_MAX) ? old_code : new_code;
  endfunction

  // Word decode shared by every register
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [11:0]       offset);
    reg_hit = (addr == ADDR_W'(offset));
  endfunction

  // Bus phases; the slave adds no wait state and is ready in the first access cycle
  wire logic setup_phase = psel & ~penable;
  wire logic access_done = psel & penable & pready_reg;
  wire logic wr_strobe   = access_done & pwrite;
  wire logic rd_setup    = setup_phase & ~pwrite;

  // Register select
  wire logic hit_enable = reg_hit(paddr, ENABLE_OFFSET);
  wire logic hit_sps    = reg_hit(paddr, SPS_OFFSET);
  wire logic hit_chsel  = reg_hit(paddr, CHSEL_OFFSET);
  wire logic hit_status = reg_hit(paddr, STATUS_OFFSET);
  wire logic hit_any    = hit_enable | hit_sps | hit_chsel | hit_status;
  wire logic wr_enable  = wr_strobe & hit_enable;
  wire logic wr_sps     = wr_strobe & hit_sps;
  wire logic wr_chsel   = wr_strobe & hit_chsel;
  // Unmapped words answer with an error and are never written
  wire logic bad_setup  = setup_phase & ~hit_any;

  wire logic serial_unit0_clock_on =
    peripheral_clock_enable_reg[UNIT0_ENABLE_BIT];
  wire logic [CODE_W-1:0] prescaler_divide_code_a =
    serial_prescaler_reg[CODE_A_LSB +: CODE_W];
  wire logic [CODE_W-1:0] prescaler_divide_code_b =
    serial_prescaler_reg[CODE_B_LSB +: CODE_W];

  // A prohibited code leaves its nibble as it was
  wire logic [CODE_W-1:0] wr_code_a = legal_code(
    pwdata[CODE_A_LSB +: CODE_W], prescaler_divide_code_a);
  wire logic [CODE_W-1:0] wr_code_b = legal_code(
    pwdata[CODE_B_LSB +: CODE_W], prescaler_divide_code_b);
  wire logic [SPS_W-1:0] sps_next =
    SPS_W'({wr_code_b, wr_code_a}) & SPS_WRITABLE;
  wire logic [ENABLE_W-1:0] enable_next =
    pwdata[ENABLE_W-1:0];
  wire logic [CHANNELS-1:0] chsel_next =
    pwdata[CHANNELS-1:0];

  // Gate and phase move at one edge while the phase is low,
  // so the unit never sees a shortened high or low half
  wire logic gate_open_next =
    unit_phase_reg ? gate_open_reg : serial_unit0_clock_on;
  wire logic unit_phase_next =
    gate_open_next ? ~unit_phase_reg : 1'b0;

  // Divider cleared while gated so a stopped unit sees no ticks
  wire logic [DIV_W-1:0] div_count_next =
    gate_open_reg ? DIV_W'(div_count_reg + DIV_W'(1)) : {DIV_W{1'b0}};

  // Tick when the low code bits of the counter are all ones
  wire logic tick_a_next =
    gate_open_reg & divide_tick(prescaler_divide_code_a, div_count_reg);
  wire logic tick_b_next =
    gate_open_reg & divide_tick(prescaler_divide_code_b, div_count_reg);

  logic [CHANNELS-1:0] chan_tick_next;

  for (genvar g = 0; g < CHANNELS; g++)
  begin : chan_sel_g
    assign chan_tick_next[g] = channel_clock_source_reg[g] ?
                               tick_b_next : tick_a_next;
  end

  // Status is read only; writes to it are dropped
  wire logic [31:0] status_word =
    32'({gate_open_reg, tick_b_reg, tick_a_reg});
  wire logic [31:0] read_mux =
    hit_enable ? 32'(peripheral_clock_enable_reg) :
    hit_sps    ? 32'(serial_prescaler_reg) :
    hit_chsel  ? 32'(channel_clock_source_reg) :
    hit_status ? status_word :
                 32'h0000_0000;

  // APB slave: ready in the cycle after every setup
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup_phase;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pslverr_reg <= bad_setup;
    end
  end

  // Read data stands only in the access cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      prdata_reg <= rd_setup ? read_mux : 32'h0000_0000;
    end
  end

  // All eight bits kept; only the unit 0 bit acts
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      peripheral_clock_enable_reg <= ENABLE_RESET;
    end
    else if (wr_enable)
    begin
      peripheral_clock_enable_reg <= enable_next;
    end
  end

  // Writable even with the gate shut; sequencing is software's
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      serial_prescaler_reg <= SPS_RESET;
    end
    else if (wr_sps)
    begin
      serial_prescaler_reg <= sps_next;
    end
  end

  // A set bit routes clock B to that channel
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      channel_clock_source_reg <= '0;
    end
    else if (wr_chsel)
    begin
      channel_clock_source_reg <= chsel_next;
    end
  end

  // Unit clock toggles each cycle while the gate is open
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      unit_phase_reg <= 1'b0;
    end
    else
    begin
      unit_phase_reg <= unit_phase_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      gate_open_reg <= 1'b0;
    end
    else
    begin
      gate_open_reg <= gate_open_next;
    end
  end

  // Counter runs only while the gate is open
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_count_reg <= '0;
    end
    else
    begin
      div_count_reg <= div_count_next;
    end
  end

  // Ticks are one-cycle enable pulses, not true clocks
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tick_a_reg <= 1'b0;
    end
    else
    begin
      tick_a_reg <= tick_a_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tick_b_reg <= 1'b0;
    end
    else
    begin
      tick_b_reg <= tick_b_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      chan_tick_reg <= '0;
    end
    else
    begin
      chan_tick_reg <= chan_tick_next;
    end
  end

  // Every output leaves straight from a flop
  assign pready                  = pready_reg;
  assign pslverr                 = pslverr_reg;
  assign prdata                  = prdata_reg;
  assign unit_clock              = unit_phase_reg;
  assign unit_clock_on           = gate_open_reg;
  assign prescaled_clock_a       = tick_a_reg;
  assign prescaled_clock_b       = tick_b_reg;
  assign channel_operation_clock = chan_tick_reg;

endmodule

// [sau_clock_pkg.sv]
/*
  Constants for the serial unit clock gate and prescaler: APB register
  offsets, field positions, reset values and divider limits.
  Assumes a 32-bit APB with one aligned word per register.
*/
package serial_clock_pkg;
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] ENABLE_OFFSET   = 12'h000;
  localparam logic [11:0] SPS_OFFSET      = 12'h004;
  localparam logic [11:0] CHSEL_OFFSET    = 12'h008;
  localparam logic [11:0] STATUS_OFFSET   = 12'h00C;
  localparam int unsigned ENABLE_W        = 8;
  localparam int unsigned SPS_W           = 16;
  localparam int unsigned UNIT0_ENABLE_BIT = 2;
  localparam int unsigned CODE_W          = 4;
  localparam int unsigned CODE_A_LSB      = 0;
  localparam int unsigned CODE_B_LSB      = 4;
  localparam logic [3:0]  CODE_MAX        = 4'hB;
  localparam int unsigned DIV_W           = 11;
  localparam logic [7:0]  ENABLE_RESET    = 8'h00;
  localparam logic [15:0] SPS_RESET       = 16'h0000;
  localparam logic [15:0] SPS_WRITABLE    = 16'h00FF;
endpackage

// [sau_clock_checker.sv]
/* Port assertions for the serial unit clock gate.
   Assumes package offsets and no APB wait state. */
module serial_unit_clock_checker
  import serial_clock_pkg::*;
#(parameter int unsigned CHANNELS = 4)
(
  input wire logic                clk,
  input wire logic                srst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire logic                unit_clock,
  input wire logic                unit_clock_on,
  input wire logic                prescaled_clock_a,
  input wire logic                prescaled_clock_b,
  input wire logic [CHANNELS-1:0] channel_operation_clock
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (srst);
  wire on_wr = psel && penable && pready && pwrite
    && paddr == ENABLE_OFFSET && pwdata[UNIT0_ENABLE_BIT];
  ready_once_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle");
  clock_off_a: assert property (!unit_clock_on |-> !unit_clock)
    else $error("unit clock while off");
  clock_runs_a: assert property
    (unit_clock_on && $past(unit_clock_on) |-> unit_clock != $past(unit_clock))
    else $error("unit clock stuck");
  gate_low_a: assert property ($changed(unit_clock_on) |-> !$past(unit_clock))
    else $error("gate moved while high");
  open_soon_a: assert property (on_wr |-> ##[1:3] unit_clock_on)
    else $error("gate did not open");
  upper_zero_a: assert property
    (pready && !pwrite && paddr == SPS_OFFSET |-> prdata[31:8] == 24'h000000)
    else $error("prescaler upper bits set");
  bad_addr_a: assert property (pready && paddr > STATUS_OFFSET |-> pslverr)
    else $error("no error on unmapped");
  idle_data_a: assert property (!pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("data outside access");
  cover property (on_wr);
  cover property ($fell(unit_clock_on));
  cover property (prescaled_clock_b && channel_operation_clock[0]);
endmodule
bind serial_unit_clock_gate_prescaler serial_unit_clock_checker
  #(.CHANNELS(CHANNELS)) chk_u (
  .clk                     (clk),
  .srst                    (srst),
  .psel                    (psel),
  .penable                 (penable),
  .pwrite                  (pwrite),
  .paddr                   (paddr),
  .pwdata                  (pwdata),
  .pready                  (pready),
  .prdata                  (prdata),
  .pslverr                 (pslverr),
  .unit_clock              (unit_clock),
  .unit_clock_on           (unit_clock_on),
  .prescaled_clock_a       (prescaled_clock_a),
  .prescaled_clock_b       (prescaled_clock_b),
  .channel_operation_clock (channel_operation_clock)
);

// [sau_clock_gate_tb.sv]
/* Bench: APB accesses and prescaled tick period checks.
   Assumes package offsets; the bench drives every input port. */
module serial_unit_clock_gate_prescaler_tb import serial_clock_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0]       pwdata = 32'h00000000;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, unit_clock, unit_clock_on, err;
  logic [3:0]        ticks;
  int                fails = 0;
  int                checks_done = 0;
  always #2.5 clk = ~clk;
  serial_unit_clock_gate_prescaler #(.CHANNELS(2)) dut_u (.clk, .srst,
    .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .unit_clock,
    .unit_clock_on, .prescaled_clock_a(ticks[0]),
    .prescaled_clock_b(ticks[1]), .channel_operation_clock(ticks[3:2]));
  task automatic chk(input string s, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", s, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    if (n == 20) fails++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Skip two ticks so a stale count from the old code is not measured
  task automatic per(input int i, input int e);
    int n = 0;
    repeat (2)
      do @(posedge clk); while (ticks[i] !== 1'b1);
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ticks[i] !== 1'b1);
    chk("tick period", 32'(n), 32'(e));
  endtask
  task automatic stop_test;
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, SPS_OFFSET, 32'h00000000);
    chk("prescaler reset", rd, {16'h0000, SPS_RESET});
    apb(1'b1, ENABLE_OFFSET, 32'h00000004);
    apb(1'b0, ENABLE_OFFSET, 32'h00000000);
    chk("enable reg", rd, 32'h00000004);
    chk("gate on", unit_clock_on, 1'b1);
    apb(1'b1, CHSEL_OFFSET, 32'h00000001);
    for (int c = 0; c < 12; c++)
    begin
      apb(1'b1, SPS_OFFSET, {24'h000000, 4'(c), 4'(11 - c)});
      for (int i = 0; i < 4; i++)
        per(i, (i == 0 || i == 3) ? 1 << (11 - c) : 1 << c);
    end
    apb(1'b1, SPS_OFFSET, 32'h0000FFC5);
    apb(1'b0, SPS_OFFSET, 32'h00000000);
    chk("code b kept", rd, 32'h000000B5);
    apb(1'b1, SPS_OFFSET, 32'h0000002C);
    apb(1'b0, SPS_OFFSET, 32'h00000000);
    chk("code a kept", rd, 32'h00000025);
    apb(1'b0, 12'h010, 32'h00000000);
    chk("unmapped error", err, 1'b1);
    apb(1'b1, ENABLE_OFFSET, 32'h00000000);
    repeat (3) @(posedge clk);
    chk("gate off", {unit_clock_on, unit_clock}, 2'b00);
    stop_test();
  end
  initial
  begin
    #400000;
    fails++;
    stop_test();
  end
endmodule
